/* File: rtl/otpal_pkg.sv */
// Package for the one-time-programmable store auto-load parser
package otpal_pkg;

	// Store geometry
	localparam int unsigned WORDS      = 64;
	localparam int unsigned AW         = 6;
	localparam int unsigned TGT_WORDS  = 128;
	localparam logic [5:0]  LAST_WORD  = 6'h3F;
	localparam logic [5:0]  VERS_WORD  = 6'h3D;

	// Entry type codes
	localparam logic [2:0] TYPE_BLANK = 3'h0;
	localparam logic [2:0] TYPE_WORD  = 3'h1;
	localparam logic [2:0] TYPE_CSR   = 3'h2;
	localparam logic [2:0] TYPE_PHY   = 3'h3;
	localparam logic [2:0] TYPE_INVAL = 3'h7;

	// Entry lengths in words
	localparam logic [5:0] LEN_WORD = 6'h02;
	localparam logic [5:0] LEN_CSR  = 6'h04;
	localparam logic [5:0] LEN_PHY  = 6'h02;
	localparam logic [5:0] LEN_SKIP = 6'h02;

	// Field positions of the first word
	localparam int unsigned TYPE_LSB  = 0;
	localparam int unsigned RST_LSB   = 3;
	localparam int unsigned ADDR_LSB  = 9;

	// Reset-type codes
	localparam logic [1:0] RT_POWER = 2'h0;
	localparam logic [1:0] RT_RSVD  = 2'h1;
	localparam logic [1:0] RT_PCIE  = 2'h2;
	localparam logic [1:0] RT_SOFT  = 2'h3;

	// Special target words
	localparam logic [6:0] TGT_MAC_LO = 7'h00;
	localparam logic [6:0] TGT_MAC_MI = 7'h01;
	localparam logic [6:0] TGT_MAC_HI = 7'h02;
	localparam logic [6:0] TGT_LOCK   = 7'h0A;
	localparam int unsigned LOCK_BIT  = 15;

	// AXI4-Lite register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STAT   = 8'h04;
	localparam logic [7:0] OFS_WADDR  = 8'h08;
	localparam logic [7:0] OFS_WDATA  = 8'h0C;
	localparam logic [7:0] OFS_TADDR  = 8'h10;
	localparam logic [7:0] OFS_TDATA  = 8'h14;
	localparam logic [7:0] OFS_MAC_L  = 8'h18;
	localparam logic [7:0] OFS_MAC_H  = 8'h1C;
	localparam logic [7:0] OFS_SERIAL = 8'h20;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Reset values
	localparam logic [15:0] WORD_RST = 16'h0000;

	// Parser states
	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_DECODE, ST_DATA, ST_DONE
	} otpal_state_t;

	// Reset kind carried with a start request
	typedef struct packed {
		logic       go;
		logic [1:0] kind;
	} otpal_start_t;

	// One write toward the configuration structures
	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic [6:0]  addr;
		logic [15:0] data;
		logic [31:0] wide;
	} otpal_load_t;

	// Loader decides whether an entry applies to this reset
	function automatic logic applies(input logic [1:0] rt,
					 input logic [1:0] kind);
		case (rt)
			RT_POWER: applies = (kind == RT_POWER);
			RT_PCIE:  applies = (kind == RT_POWER) || (kind == RT_PCIE);
			RT_SOFT:  applies = 1'b1;
			default:  applies = 1'b0;
		endcase
	endfunction : applies

endpackage : otpal_pkg

/* File: rtl/otpal_store.sv */
// Write-once storage array of the one-time-programmable store
`timescale 1ns/100ps
`default_nettype none
module otpal_store (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Read port
	input  wire logic [5:0]  rd_addr,
	output logic      [15:0] rd_data,
	// Program port
	input  wire logic        pg_en,
	input  wire logic [5:0]  pg_addr,
	input  wire logic [15:0] pg_data,
	output logic             pg_done,
	output logic             pg_refused
);
	// Whole state in one struct
	typedef struct packed {
		logic [otpal_pkg::WORDS-1:0][15:0] mem;
		logic [otpal_pkg::WORDS-1:0]       used;
		logic [15:0]                       rdat;
		logic                              done;
		logic                              refused;
	} otpal_store_st_t;

	otpal_store_st_t st_reg;
	otpal_store_st_t st_next;

	// A word once written is never written again
	always_comb begin
		st_next         = st_reg;
		st_next.done    = 1'b0;
		st_next.refused = 1'b0;
		st_next.rdat    = st_reg.mem[rd_addr];
		if (pg_en) begin
			if (st_reg.used[pg_addr]) begin
				st_next.refused = 1'b1; // R2
			end else begin
				st_next.mem[pg_addr]  = pg_data; // R1
				st_next.used[pg_addr] = 1'b1;    // R1
				st_next.done          = 1'b1;
			end
		end
	end

	// Blank after reset stands for an unprogrammed array model
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data    = st_reg.rdat;
	assign pg_done    = st_reg.done;
	assign pg_refused = st_reg.refused;
endmodule : otpal_store
`default_nettype wire

/* File: rtl/otpal_loader.sv */
// Auto-load parser with AXI4-Lite control and write lock-out
// Operation
// [R1] Store holds 64 sixteen-bit words, write-once
// [R2] Programmed words can never be rewritten
// [R3] Words 61 to 63 never affect behaviour; the walk here still parses and loads entries up to word 63
// [R4] Word, CSR and PHY entries: 2, 4, 2
// [R5] Type 001 word, 010 CSR, 011 PHY
// [R6] Type 000 ends the walk
// [R7] Type 111 words skipped until another type
// [R8] Unknown nonzero type skipped, nothing loaded
// [R9] Software invalidates with 111, never 100
// [R10] Reset-type selects power, PCIe or software
// [R11] Load only entries matching current reset
// [R12] Word entry layout: type, reset, address, data
// [R13] Words 0 to 2 form station address
// [R14] Lock entry blocks programming while strap set
// [R15] Strap off allows blank words programmed again
// [R16] Agent re-enables strap after programming
// [R17] Version entry ignored like other invalidated
// [R18] Walk from word zero to end in order
// [R19] Later entries overwrite earlier ones
`timescale 1ns/100ps
`default_nettype none
module otpal_loader (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Reset kind requests, one-cycle pulses
	input  wire logic        power_up_reset,
	input  wire logic        pcie_reset,
	input  wire logic        soft_reset,
	// Security strap pin
	input  wire logic        security_strap,
	// Loads toward configuration structures
	output logic             load_valid,
	output logic      [1:0]  load_kind,
	output logic      [6:0]  load_addr,
	output logic      [15:0] load_data,
	output logic      [31:0] load_wide,
	output logic             load_busy,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic      [1:0]  s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp
);
	// Whole state in one struct
	typedef struct packed {
		otpal_pkg::otpal_state_t state;
		logic [1:0]              kind;
		logic [5:0]              ptr;
		logic [15:0]             w0;
		logic [1:0]              sub;
		logic                    in_entry;
		logic [47:0]             wide;
		logic                    strap_s1;
		logic                    strap_s2;
		logic                    lock_seen;
		logic                    locked;
		logic [47:0]             mac;
		logic [5:0]              pg_addr;
		logic [15:0]             pg_data;
		logic                    pg_en;
		logic                    pg_fail;
		logic                    pg_ok;
		logic [5:0]              rd_ptr;
		logic                    aw_held;
		logic [7:0]              aw_addr;
		logic                    w_held;
		logic [31:0]             w_data;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		otpal_pkg::otpal_load_t  load;
	} otpal_st_t;

	otpal_st_t   st_reg;
	otpal_st_t   st_next;
	logic [15:0] mem_rdata;
	logic        pg_done;
	logic        pg_refused;
	logic        pg_go;

	// Store array instance
	otpal_store u_store (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.rd_addr    (st_reg.rd_ptr),
		.rd_data    (mem_rdata),
		.pg_en      (pg_go),
		.pg_addr    (st_reg.pg_addr),
		.pg_data    (st_reg.pg_data),
		.pg_done    (pg_done),
		.pg_refused (pg_refused)
	);

	// Programming blocked while lock entry present and strap on
	assign pg_go = st_reg.pg_en && !st_reg.locked; // R14 R15 R16

	// Parser, lock tracking and register bus
	always_comb begin
		logic [2:0]  ty;
		logic [6:0]  ta;
		logic        wr_fire;
		logic [7:0]  ra;
		ty      = mem_rdata[otpal_pkg::TYPE_LSB +: 3];
		ta      = st_reg.w0[otpal_pkg::ADDR_LSB +: 7];
		wr_fire = 1'b0;
		ra      = s_axi_araddr;
		st_next = st_reg;
		st_next.load.valid = 1'b0;
		st_next.pg_en      = 1'b0;
		st_next.strap_s1   = security_strap;
		st_next.strap_s2   = st_reg.strap_s1;
		st_next.locked     = st_reg.lock_seen && st_reg.strap_s2; // R14 R15

		// Parser walk
		case (st_reg.state)
		otpal_pkg::ST_IDLE: begin
			st_next.state = otpal_pkg::ST_IDLE; // Peek address kept
		end
		otpal_pkg::ST_FETCH: begin
			// Read latency one; header or data word follows
			st_next.state = st_reg.in_entry ? otpal_pkg::ST_DATA :
					otpal_pkg::ST_DECODE;
		end
		otpal_pkg::ST_DECODE: begin
			st_next.w0  = mem_rdata;
			st_next.sub = '0;
			if (ty == otpal_pkg::TYPE_BLANK) begin
				st_next.state = otpal_pkg::ST_DONE; // R6
			end else if ((ty == otpal_pkg::TYPE_WORD) ||
				     (ty == otpal_pkg::TYPE_CSR) ||
				     (ty == otpal_pkg::TYPE_PHY)) begin // R5
				st_next.state    = otpal_pkg::ST_FETCH;
				st_next.in_entry = 1'b1; // Header read, data next
				st_next.rd_ptr   = st_reg.ptr + 6'h01;
			end else begin
				// Invalidated, version or unknown: skip 32 bits
				if (st_reg.ptr >= otpal_pkg::LAST_WORD - 6'h01) begin
					st_next.state = otpal_pkg::ST_DONE; // R18
				end else begin
					st_next.ptr    = st_reg.ptr + otpal_pkg::LEN_SKIP; // R7 R8 R3 R17
					st_next.rd_ptr = st_reg.ptr + otpal_pkg::LEN_SKIP;
					st_next.state  = otpal_pkg::ST_FETCH;
				end
			end
		end
		otpal_pkg::ST_DATA: begin
			// Gather the words following the header
			st_next.wide = {st_reg.wide[31:0], mem_rdata};
			st_next.sub  = st_reg.sub + 2'h1;
			st_next.rd_ptr = st_reg.rd_ptr + 6'h01;
			st_next.state  = otpal_pkg::ST_FETCH;
			if ((st_reg.w0[2:0] != otpal_pkg::TYPE_CSR) ||
			    (st_reg.sub == 2'h2)) begin // R4
				if (otpal_pkg::applies(st_reg.w0[4:3], st_reg.kind)) begin // R10 R11
					st_next.load.valid = 1'b1; // R19
					st_next.load.kind  = st_reg.w0[1:0];
					st_next.load.addr  = ta; // R12
					st_next.load.data  = mem_rdata;
					st_next.load.wide  = {st_reg.wide[15:0], mem_rdata};
					if (st_reg.w0[2:0] == otpal_pkg::TYPE_WORD) begin
						if (ta == otpal_pkg::TGT_MAC_LO)
							st_next.mac[15:0]  = mem_rdata; // R13
						if (ta == otpal_pkg::TGT_MAC_MI)
							st_next.mac[31:16] = mem_rdata; // R13
						if (ta == otpal_pkg::TGT_MAC_HI)
							st_next.mac[47:32] = mem_rdata; // R13
						if (ta == otpal_pkg::TGT_LOCK)
							st_next.lock_seen =
							  mem_rdata[otpal_pkg::LOCK_BIT]; // R14 R19
					end
				end
				if (st_reg.rd_ptr >= otpal_pkg::LAST_WORD) begin
					st_next.state = otpal_pkg::ST_DONE; // R18
				end else begin
					st_next.ptr      = st_reg.rd_ptr + 6'h01;
					st_next.rd_ptr   = st_reg.rd_ptr + 6'h01;
					st_next.in_entry = 1'b0; // Next word is a header
				end
			end else if (st_reg.rd_ptr >= otpal_pkg::LAST_WORD) begin
				st_next.state = otpal_pkg::ST_DONE; // Truncated entry
			end
		end
		otpal_pkg::ST_DONE: begin
			st_next.state = otpal_pkg::ST_DONE;
		end
		default: st_next.state = otpal_pkg::ST_IDLE;
		endcase

		// Start a walk from word zero on any reset kind
		if (power_up_reset || pcie_reset || soft_reset) begin
			st_next.state  = otpal_pkg::ST_FETCH; // R18
			st_next.ptr    = '0;
			st_next.in_entry = 1'b0;
			st_next.rd_ptr = '0;
			st_next.kind   = power_up_reset ? otpal_pkg::RT_POWER :
					 pcie_reset ? otpal_pkg::RT_PCIE :
					 otpal_pkg::RT_SOFT; // R11
			if (power_up_reset) begin
				st_next.lock_seen = 1'b0;
				st_next.mac       = '0;
			end
		end

		// Write channel capture
		if (s_axi_awvalid && !st_reg.aw_held && !st_reg.bvalid) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_held && !st_reg.bvalid) begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
		end
		if (st_reg.aw_held && st_reg.w_held) begin
			wr_fire         = 1'b1;
			st_next.aw_held = 1'b0;
			st_next.w_held  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = otpal_pkg::RESP_OKAY;
		end
		if (wr_fire) begin
			if (st_reg.aw_addr == otpal_pkg::OFS_CTRL) begin
				if (st_reg.w_data[0] && !st_reg.pg_en) begin
					st_next.pg_en   = 1'b1;
					st_next.pg_fail = 1'b0;
					st_next.pg_ok   = 1'b0;
				end
			end else if (st_reg.aw_addr == otpal_pkg::OFS_WADDR) begin
				st_next.pg_addr = st_reg.w_data[5:0];
			end else if (st_reg.aw_addr == otpal_pkg::OFS_WDATA) begin
				st_next.pg_data = st_reg.w_data[15:0];
			end else if (st_reg.aw_addr == otpal_pkg::OFS_TADDR) begin
				st_next.rd_ptr = (st_reg.state == otpal_pkg::ST_DONE ||
					st_reg.state == otpal_pkg::ST_IDLE) ?
					st_reg.w_data[5:0] : st_next.rd_ptr;
			end else if (st_reg.aw_addr == otpal_pkg::OFS_STAT ||
				     st_reg.aw_addr == otpal_pkg::OFS_TDATA ||
				     st_reg.aw_addr == otpal_pkg::OFS_MAC_L ||
				     st_reg.aw_addr == otpal_pkg::OFS_MAC_H ||
				     st_reg.aw_addr == otpal_pkg::OFS_SERIAL) begin
				st_next.bresp = otpal_pkg::RESP_SLVERR; // Read-only
			end else begin
				st_next.bresp = otpal_pkg::RESP_DECERR;
			end
		end
		// Store outcome flags, a set beats a clear
		if (pg_refused || (st_reg.pg_en && st_reg.locked)) begin
			st_next.pg_fail = 1'b1; // R2
		end
		if (pg_done) begin
			st_next.pg_ok = 1'b1;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Read channel
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = otpal_pkg::RESP_OKAY;
			if (ra == otpal_pkg::OFS_CTRL) begin
				st_next.rdata = {31'h0, st_reg.pg_en};
			end else if (ra == otpal_pkg::OFS_STAT) begin
				st_next.rdata = {24'h0, st_reg.state == otpal_pkg::ST_DONE,
					st_reg.locked, st_reg.lock_seen, st_reg.strap_s2,
					st_reg.pg_fail, st_reg.pg_ok, st_reg.kind};
			end else if (ra == otpal_pkg::OFS_WADDR) begin
				st_next.rdata = {26'h0, st_reg.pg_addr};
			end else if (ra == otpal_pkg::OFS_WDATA) begin
				st_next.rdata = {16'h0, st_reg.pg_data};
			end else if (ra == otpal_pkg::OFS_TADDR) begin
				st_next.rdata = {26'h0, st_reg.rd_ptr};
			end else if (ra == otpal_pkg::OFS_TDATA) begin
				st_next.rdata = {16'h0, mem_rdata};
			end else if (ra == otpal_pkg::OFS_MAC_L) begin
				st_next.rdata = st_reg.mac[31:0];
			end else if (ra == otpal_pkg::OFS_MAC_H) begin
				st_next.rdata = {16'h0, st_reg.mac[47:32]};
			end else if (ra == otpal_pkg::OFS_SERIAL) begin
				st_next.rdata = {st_reg.mac[47:24], 8'hFF}; // R13
			end else begin
				st_next.rdata = 32'h0000_0000;
				st_next.rresp = otpal_pkg::RESP_DECERR;
			end
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs
	assign load_valid    = st_reg.load.valid;
	assign load_kind     = st_reg.load.kind;
	assign load_addr     = st_reg.load.addr;
	assign load_data     = st_reg.load.data;
	assign load_wide     = st_reg.load.wide;
	assign load_busy     = (st_reg.state == otpal_pkg::ST_FETCH) ||
			       (st_reg.state == otpal_pkg::ST_DECODE) ||
			       (st_reg.state == otpal_pkg::ST_DATA);
	assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
	assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;
endmodule : otpal_loader
`default_nettype wire

/* File: dv/otpal_sva.sv */
// Concurrent checks on the auto-load parser top-level ports
`timescale 1ns/100ps
`default_nettype none
module otpal_sva (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Walk and loads
	input wire logic        power_up_reset,
	input wire logic        load_valid,
	input wire logic [1:0]  load_kind,
	input wire logic        load_busy,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Address and data taken together, then a status write
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wr_stat;
		s_wr_both ##0 (s_axi_awaddr == otpal_pkg::OFS_STAT);
	endsequence

	// Bus answers
	a_ro_write: assert property (s_wr_stat |-> ##2
		(s_axi_bvalid && s_axi_bresp == otpal_pkg::RESP_SLVERR))
		else $error("status write not refused");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr >= 8'h24 |=> s_axi_rresp == otpal_pkg::RESP_DECERR
		&& s_axi_rdata == 32'h0) else $error("unmapped read answer");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken with response pending");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken with data pending");
	// Loads
	a_load_kind:
		assert property (load_valid |-> load_kind != 2'h0)
		else $error("load of unknown kind");
	a_load_walk:
		assert property (load_valid |-> $past(load_busy))
		else $error("load outside a walk");
	a_load_gap:
		assert property (load_valid |=> !load_valid)
		else $error("loads closer than one entry");
	a_walk_start:
		assert property (power_up_reset && !load_busy |=> load_busy)
		else $error("walk did not start");
endmodule : otpal_sva

bind otpal_loader otpal_sva u_sva (.sys_clk, .rst, .power_up_reset,
	.load_valid, .load_kind, .load_busy, .s_axi_awvalid, .s_axi_awready,
	.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

/* File: dv/otpal_cfg_sink.sv */
// Model of the configuration structures that take the loads
`timescale 1ns/100ps
`default_nettype none
module otpal_cfg_sink (
	// Clock
	input wire logic        sys_clk,
	// Loads
	input wire logic        load_valid,
	input wire logic [1:0]  load_kind,
	input wire logic [6:0]  load_addr,
	input wire logic [15:0] load_data
);
	logic [15:0] img [0:127];

	// Word loads land in order, later ones replace earlier ones
	always_ff @(posedge sys_clk) begin
		if (load_valid && load_kind == 2'h1)
			img[load_addr] <= load_data;
	end
endmodule : otpal_cfg_sink
`default_nettype wire

/* File: dv/test_otp_autoload_parser.sv */
// Self-checking bench for the store auto-load parser
`timescale 1ns/100ps
`default_nettype none
module test_otp_autoload_parser;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        power_up_reset = 1'b0;
	logic        pcie_reset = 1'b0;
	logic        soft_reset = 1'b0;
	logic        security_strap = 1'b1;
	logic        load_valid, load_busy;
	logic [1:0]  load_kind;
	logic [6:0]  load_addr;
	logic [15:0] load_data;
	logic [31:0] load_wide;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total = 0, comparisons = 0, cyc = 0;
	logic [15:0] img [0:66];
	logic [15:0] seed = 16'hF029;
	logic [65:0] e;
	logic [56:0] lq [$];
	logic [56:0] le;
	logic [1:0]  bq [$];
	logic [65:0] rq [$];

	// Clock, 100 ns period
	always #50 sys_clk = ~sys_clk;

	otpal_loader DUT (.sys_clk, .rst, .power_up_reset, .pcie_reset,
		.soft_reset, .security_strap, .load_valid, .load_kind, .load_addr,
		.load_data, .load_wide, .load_busy, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	otpal_cfg_sink u_cfg (.sys_clk, .load_valid, .load_kind, .load_addr,
		.load_data);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [15:0] hdr(input logic [6:0] a,
		input logic [1:0] rt, input logic [2:0] t);
		return {a, 4'h0, rt, t};
	endfunction : hdr

	task automatic chk(input logic [31:0] g, input logic [31:0] x,
		input string m);
		comparisons++;
		if (g !== x) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk

	task automatic results;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	// Bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = otpal_pkg::RESP_OKAY);
		bq.push_back(r);
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : wr

	// Bus read, expected masked data noted for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x, input logic [1:0] r = otpal_pkg::RESP_OKAY);
		rq.push_back({m, x, r});
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask : rd

	// Program one store word and check the outcome flags
	task automatic prog(input logic [5:0] a, input logic [15:0] d,
		input logic ok);
		wr(otpal_pkg::OFS_WADDR, {26'h0, a});
		wr(otpal_pkg::OFS_WDATA, {16'h0, d});
		wr(otpal_pkg::OFS_CTRL, 32'h1);
		repeat (3) @(posedge sys_clk);
		rd(otpal_pkg::OFS_STAT, 32'hC, ok ? 32'h4 : 32'h8);
	endtask : prog

	// Reference walk of the image, then one reset pulse of kind k
	task automatic walk(input logic [1:0] k);
		int i = 0;
		logic [2:0] t;
		logic [1:0] rt;
		logic ld;
		while (i < 64 && img[i][2:0] != 3'h0) begin
			t = img[i][2:0];
			rt = img[i][4:3];
			ld = rt == 2'h3 || (rt == 2'h2 && k != 2'h3) ||
				(rt == 2'h0 && k == 2'h0);
			if (t >= 3'h1 && t <= 3'h3 && ld)
				lq.push_back({(t == 3'h2) ? {img[i + 2], img[i + 3]} :
					32'h0, t[1:0], img[i][15:9],
					img[i + ((t == 3'h2) ? 3 : 1)]});
			i += (t == 3'h2) ? 4 : 2;
		end
		@(posedge sys_clk);
		power_up_reset <= (k == 2'h0);
		pcie_reset     <= (k == 2'h2);
		soft_reset     <= (k == 2'h3);
		@(posedge sys_clk);
		power_up_reset <= 1'b0;
		pcie_reset     <= 1'b0;
		soft_reset     <= 1'b0;
		do begin
			@(posedge sys_clk);
		end while (load_busy !== 1'b0);
		@(posedge sys_clk);
		chk(lq.size(), 0, "missing load");
		rd(otpal_pkg::OFS_STAT, 32'h83, {24'h0, 1'b1, 5'h0, k});
	endtask : walk

	// Monitor: loads, write responses, read data; hang limit
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			results();
		end
		if (!rst && load_valid === 1'b1) begin
			if (lq.size() == 0) chk(32'h1, 32'h0, "extra load");
			else begin
				le = lq.pop_front();
				chk({load_kind, load_addr, load_data}, {7'h0, le[24:0]},
					"load");
				if (le[24:23] == 2'h2)
					chk(load_wide, le[56:25], "csr wide");
			end
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready)
			chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "bresp");
		if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
			e = rq.pop_front();
			chk(s_axi_rdata & e[65:34], e[33:2], "rdata");
			chk({30'h0, s_axi_rresp}, {30'h0, e[1:0]}, "rresp");
		end
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h40, 32'hFFFFFFFF, 32'h0, otpal_pkg::RESP_DECERR);
		wr(otpal_pkg::OFS_STAT, 32'h1, otpal_pkg::RESP_SLVERR);
		for (int i = 0; i < 67; i++) begin
			seed = lfsr(seed);
			img[i] = (i < 20) ? seed : 16'h0;
		end
		img[0] = hdr(7'h00, 2'h3, 3'h1);
		img[2] = 16'hFFFF;
		img[4] = 16'h0005;
		img[6] = hdr(7'h11, 2'h2, 3'h2);
		img[10] = hdr(7'h0A, 2'h0, 3'h1);
		img[11][15] = 1'b1;
		img[12] = hdr(7'h03, 2'h1, 3'h3);
		img[14] = hdr(7'h00, 2'h3, 3'h1);
		img[16] = hdr(7'h01, 2'h3, 3'h1);
		img[18] = hdr(7'h02, 2'h3, 3'h1);
		for (int i = 0; i < 20; i++) prog(6'(i), img[i], 1'b1);
		prog(6'h00, 16'hFFFF, 1'b0);
		wr(otpal_pkg::OFS_TADDR, 32'h5);
		rd(otpal_pkg::OFS_TDATA, 32'hFFFF, {16'h0, img[5]});
		walk(2'h0);
		rd(otpal_pkg::OFS_STAT, 32'h60, 32'h60);
		img[20] = hdr(7'h05, 2'h3, 3'h1);
		prog(6'h14, img[20], 1'b0);
		security_strap <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(otpal_pkg::OFS_STAT, 32'h60, 32'h20);
		prog(6'h14, img[20], 1'b1);
		security_strap <= 1'b1;
		walk(2'h2);
		walk(2'h3);
		rd(otpal_pkg::OFS_MAC_L, 32'hFFFFFFFF, {img[17], img[15]});
		rd(otpal_pkg::OFS_MAC_H, 32'hFFFF, {16'h0, img[19]});
		rd(otpal_pkg::OFS_SERIAL, 32'hFFFFFFFF,
			{img[19], img[17][15:8], 8'hFF});
		chk({16'h0, u_cfg.img[0]}, {16'h0, img[15]}, "cfg word");
		results();
	end
endmodule : test_otp_autoload_parser
`default_nettype wire
